// ---- include/tfc_pkg.sv ----
// Purpose: shared constants and types for the thermal fan config registers
// Assumes: 8-bit register port, byte addresses as printed
// Notes: power-on values are all zero
package tfc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TFC_ADDR_FMT = 8'h7C;
    localparam logic [7:0] TFC_ADDR_PIN = 8'h7D;
    localparam logic [7:0] TFC_ADDR_TEST_A = 8'h7E;
    localparam logic [7:0] TFC_ADDR_TEST_B = 8'h7F;
    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] TFC_RST_FMT = 8'h00;
    localparam logic [7:0] TFC_RST_PIN = 8'h00;
    localparam logic [7:0] TFC_RST_TEST = 8'h00;
    localparam logic [7:0] TFC_MASK_FMT = 8'hEF;
    localparam logic [7:0] TFC_MASK_PIN = 8'h2F;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TFC_B_TWOS = 0;
    localparam int TFC_B_OFFR = 1;
    localparam int TFC_B_GDIR = 2;
    localparam int TFC_B_GPOL = 3;
    localparam int TFC_B_R1 = 5;
    localparam int TFC_B_LOC = 6;
    localparam int TFC_B_R2 = 7;
    localparam int TFC_B_PFN = 0;
    localparam int TFC_B_OTD = 2;
    localparam int TFC_B_FTG = 3;
    localparam int TFC_B_BYP = 5;
    // ------------------------------------------------------------
    // Limit values that disable a channel
    // ------------------------------------------------------------
    localparam logic [7:0] TFC_OFF64_DIS = 8'h00;
    localparam logic [7:0] TFC_TWOS_DIS = 8'h80;
    localparam int TFC_NCH = 3;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TFC_PIN_TACH,
        TFC_PIN_OVERTEMP,
        TFC_PIN_ALERT,
        TFC_PIN_GPIO
    } tfc_pin_fn_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tfc_req_t;
    typedef struct packed {
        logic twos_complement_select;
        logic offset_range_select;
        logic gpio_is_output;
        logic gpio_active_high;
        logic gpio_enabled;
        tfc_pin_fn_t shared_pin_function;
        logic overtemp_output_enable;
        logic overtemp_fan_target;
        logic core_voltage_attenuator_bypass;
        logic [2:0] overtemp_channel_enable;
    } tfc_ctrl_t;
endpackage

// ---- verilog/tfc_limit_check.sv ----
// Purpose: per-channel overtemperature enable from bit and limit value
// Assumes: limits are raw 8-bit register codes
// Notes: purely combinational decode registered in the top
`timescale 1ns/1ps
module tfc_limit_check #(
    parameter int NCH = 3
) (
    input wire logic twos_mode,
    input wire logic [NCH-1:0] disable_bits,
    input wire logic [NCH*8-1:0] limits,
    output logic [NCH-1:0] enable
);
    import tfc_pkg::*;
    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_ch
            logic [7:0] lim;
            logic sentinel;
            assign lim = limits[i*8 +: 8];
            // Disable code depends on the selected format
            assign sentinel = twos_mode ? (lim == TFC_TWOS_DIS) :
                (lim == TFC_OFF64_DIS); // [RULE_08] [RULE_02]
            assign enable[i] = !disable_bits[i] && !sentinel; // [RULE_07]
        end
    endgenerate
endmodule

// ---- verilog/tfc_config_regs.sv ----
// Purpose: two lockable configuration registers and two test registers
// Assumes: single-cycle register port on the device clock
// Notes: read data is registered, valid one cycle after the request
//
// How it works
// [RULE_01] Format bit picks twos complement when set, offset-64 when clear.
// [RULE_02] Changing format reinterprets stored temperature limits at once.
// [RULE_03] Offset range bit picks half-degree or one-degree offset steps.
// [RULE_04] Offset range drives the three temperature offset scalers.
// [RULE_05] In GPIO mode, direction bit makes pin input or output.
// [RULE_06] GPIO output polarity bit picks active low or active high.
// [RULE_07] Per-channel disable bits turn off that channel's overtemp limit.
// [RULE_08] Limit of -64 (offset) or -128 (twos) also disables channel.
// [RULE_09] Lock bit makes both config registers ignore further writes.
// [RULE_10] Two-bit field routes shared pin: tach, overtemp, alert, GPIO.
// [RULE_11] Overtemp output disable bit suppresses overtemp output everywhere.
// [RULE_12] Fan target bit picks full speed or programmed max on overtemp.
// [RULE_13] Bypass bit selects the unattenuated core-voltage scale.
// [RULE_14] Host must not write test registers; they are read-only here.
// [RULE_15] All four registers are zero after reset.
// [RULE_16] Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
module tfc_config_regs (
    input wire logic clock,
    input wire logic rst,
    input wire tfc_pkg::tfc_req_t req,
    input wire logic lock,
    input wire logic [23:0] overtemp_limits,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic hit,
    output tfc_pkg::tfc_ctrl_t ctrl,
    output logic [7:0] fmt_reg,
    output logic [7:0] pin_reg
);
    import tfc_pkg::*;

    default clocking cb_main @(posedge clock);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] fmt_q;
    logic [7:0] pin_q;
    logic [7:0] test_a_q;
    logic [7:0] test_b_q;
    logic [TFC_NCH-1:0] ch_en;
    logic [TFC_NCH-1:0] dis_bits;
    logic lock_q1;
    logic lock_q2;
    logic sel_fmt;
    logic sel_pin;
    logic sel_test;

    // Lock arrives from another block's domain edge, synchronised
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lock_q1 <= 1'b0;
            lock_q2 <= 1'b0;
        end else begin
            lock_q1 <= lock;
            lock_q2 <= lock_q1;
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    always_comb begin
        sel_fmt = 1'b0;
        sel_pin = 1'b0;
        sel_test = 1'b0;
        if (req.addr == TFC_ADDR_FMT) begin
            sel_fmt = 1'b1;
        end else if (req.addr == TFC_ADDR_PIN) begin
            sel_pin = 1'b1;
        end else if (req.addr == TFC_ADDR_TEST_A ||
                     req.addr == TFC_ADDR_TEST_B) begin
            sel_test = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fmt_q <= TFC_RST_FMT; // [RULE_15]
            pin_q <= TFC_RST_PIN; // [RULE_15]
        end else if (req.wr && !lock_q2) begin // [RULE_09]
            if (sel_fmt) begin
                fmt_q <= req.wdata & TFC_MASK_FMT; // [RULE_16]
            end
            if (sel_pin) begin
                pin_q <= req.wdata & TFC_MASK_PIN; // [RULE_16]
            end
        end
    end

    // Test registers hold their reset value; writes are dropped
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            test_a_q <= TFC_RST_TEST; // [RULE_15]
            test_b_q <= TFC_RST_TEST; // [RULE_15]
        end else begin
            test_a_q <= test_a_q; // [RULE_14]
            test_b_q <= test_b_q;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
            hit <= 1'b0;
        end else begin
            rvalid <= req.rd;
            hit <= req.rd && (sel_fmt || sel_pin || sel_test);
            if (!req.rd) begin
                rdata <= 8'h00;
            end else if (sel_fmt) begin
                rdata <= fmt_q;
            end else if (sel_pin) begin
                rdata <= pin_q;
            end else if (req.addr == TFC_ADDR_TEST_A) begin
                rdata <= test_a_q;
            end else if (req.addr == TFC_ADDR_TEST_B) begin
                rdata <= test_b_q;
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Channel enables
    // ------------------------------------------------------------
    assign dis_bits = {fmt_q[TFC_B_R2], fmt_q[TFC_B_LOC], fmt_q[TFC_B_R1]};

    tfc_limit_check #(
        .NCH(TFC_NCH)
    ) u_limit (
        .twos_mode(fmt_q[TFC_B_TWOS]),
        .disable_bits(dis_bits),
        .limits(overtemp_limits),
        .enable(ch_en)
    );

    // ------------------------------------------------------------
    // Decoded controls, registered
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl <= '0;
            fmt_reg <= 8'h00;
            pin_reg <= 8'h00;
        end else begin
            fmt_reg <= fmt_q;
            pin_reg <= pin_q;
            ctrl.twos_complement_select <= fmt_q[TFC_B_TWOS]; // [RULE_01]
            ctrl.offset_range_select <=
                fmt_q[TFC_B_OFFR]; // [RULE_03] [RULE_04]
            ctrl.shared_pin_function <=
                tfc_pin_fn_t'(pin_q[TFC_B_PFN +: 2]); // [RULE_10]
            ctrl.gpio_enabled <=
                pin_q[TFC_B_PFN +: 2] == 2'(TFC_PIN_GPIO);
            ctrl.gpio_is_output <= (pin_q[TFC_B_PFN +: 2] ==
                2'(TFC_PIN_GPIO)) && fmt_q[TFC_B_GDIR]; // [RULE_05]
            ctrl.gpio_active_high <= fmt_q[TFC_B_GPOL]; // [RULE_06]
            ctrl.overtemp_output_enable <= !pin_q[TFC_B_OTD]; // [RULE_11]
            ctrl.overtemp_fan_target <= pin_q[TFC_B_FTG]; // [RULE_12]
            ctrl.core_voltage_attenuator_bypass <=
                pin_q[TFC_B_BYP]; // [RULE_13]
            ctrl.overtemp_channel_enable <=
                pin_q[TFC_B_OTD] ? 3'h0 : ch_en; // [RULE_07] [RULE_11]
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_fmt_write;
        req.wr && !lock_q2 && sel_fmt;
    endsequence

    sequence s_pin_write;
        req.wr && !lock_q2 && sel_pin;
    endsequence

    sequence s_locked_write;
        req.wr && lock_q2;
    endsequence

    sequence s_read_fmt;
        req.rd && sel_fmt;
    endsequence

    sequence s_read_pin;
        req.rd && sel_pin;
    endsequence

    sequence s_read_test;
        req.rd && sel_test;
    endsequence

    sequence s_read_miss;
        req.rd && !sel_fmt && !sel_pin && !sel_test;
    endsequence

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    a_lock_blocks_write: assert property ( // [RULE_09]
        s_locked_write |=> $stable(fmt_q) && $stable(pin_q))
        else $error("write changed a locked register");

    a_write_takes_fmt: assert property ( // [RULE_16]
        s_fmt_write |=> fmt_q == ($past(req.wdata) & TFC_MASK_FMT))
        else $error("format register write lost");

    a_write_takes_pin: assert property ( // [RULE_16]
        s_pin_write |=> pin_q == ($past(req.wdata) & TFC_MASK_PIN))
        else $error("pin register write lost");

    a_fmt_copy_lags: assert property ( // [RULE_16]
        s_fmt_write |=> ##1 fmt_reg == ($past(req.wdata, 2) & TFC_MASK_FMT))
        else $error("format copy not updated");

    a_pin_copy_lags: assert property ( // [RULE_16]
        s_pin_write |=> ##1 pin_reg == ($past(req.wdata, 2) & TFC_MASK_PIN))
        else $error("pin copy not updated");

    a_lock_sync: assert property ( // [RULE_09]
        $rose(lock_q2) |-> $past(lock, 2))
        else $error("lock rose without request");

    a_fmt_quiet: assert property ( // [RULE_09]
        !(req.wr && sel_fmt) |=> $stable(fmt_q))
        else $error("format register changed unasked");

    a_pin_quiet: assert property ( // [RULE_09]
        !(req.wr && sel_pin) |=> $stable(pin_q))
        else $error("pin register changed unasked");

    a_test_stays_zero: assert property ( // [RULE_14]
        test_a_q == TFC_RST_TEST && test_b_q == TFC_RST_TEST)
        else $error("test register changed");

    a_reserved_zero: assert property ( // [RULE_16]
        fmt_q[4] == 1'b0 && pin_q[7:6] == 2'b00 && pin_q[4] == 1'b0)
        else $error("reserved bit set");

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    a_otd_kills_ch: assert property ( // [RULE_11]
        pin_q[TFC_B_OTD] |=> ctrl.overtemp_channel_enable == 3'h0)
        else $error("overtemp enable while disabled");

    a_ote_follow: assert property ( // [RULE_11]
        1'b1 |=> ctrl.overtemp_output_enable == !$past(pin_q[TFC_B_OTD]))
        else $error("overtemp output enable not followed");

    a_chan_dis_bit: assert property ( // [RULE_07]
        fmt_q[TFC_B_R1] |=> !ctrl.overtemp_channel_enable[0])
        else $error("remote 1 enabled while disabled");

    a_local_dis_bit: assert property ( // [RULE_07]
        fmt_q[TFC_B_LOC] |=> !ctrl.overtemp_channel_enable[1])
        else $error("local enabled while disabled");

    a_r2_dis_bit: assert property ( // [RULE_07]
        fmt_q[TFC_B_R2] |=> !ctrl.overtemp_channel_enable[2])
        else $error("remote 2 enabled while disabled");

    a_chan_live: assert property ( // [RULE_07]
        !pin_q[TFC_B_OTD] && !fmt_q[TFC_B_R1] &&
        overtemp_limits[7:0] != TFC_OFF64_DIS &&
        overtemp_limits[7:0] != TFC_TWOS_DIS |=>
        ctrl.overtemp_channel_enable[0])
        else $error("remote 1 disabled while enabled");

    a_sentinel_dis: assert property ( // [RULE_08]
        fmt_q[TFC_B_TWOS] && overtemp_limits[15:8] == TFC_TWOS_DIS |=>
        !ctrl.overtemp_channel_enable[1])
        else $error("twos sentinel limit not honoured");

    a_sentinel_off64: assert property ( // [RULE_08]
        !fmt_q[TFC_B_TWOS] && overtemp_limits[7:0] == TFC_OFF64_DIS |=>
        !ctrl.overtemp_channel_enable[0])
        else $error("offset sentinel limit not honoured");

    a_gpio_dir: assert property ( // [RULE_05]
        pin_q[1:0] != 2'b11 |=> !ctrl.gpio_is_output)
        else $error("gpio output outside gpio mode");

    a_gpio_out: assert property ( // [RULE_05]
        pin_q[1:0] == 2'b11 && fmt_q[TFC_B_GDIR] |=> ctrl.gpio_is_output)
        else $error("gpio output not enabled");

    a_gpio_mode: assert property ( // [RULE_05]
        1'b1 |=> ctrl.gpio_enabled == ($past(pin_q[1:0]) == 2'b11))
        else $error("gpio enable not followed");

    a_gpio_pol: assert property ( // [RULE_06]
        1'b1 |=> ctrl.gpio_active_high == $past(fmt_q[TFC_B_GPOL]))
        else $error("gpio polarity not followed");

    a_fmt_follow: assert property ( // [RULE_01]
        1'b1 |=> ctrl.twos_complement_select == $past(fmt_q[TFC_B_TWOS]))
        else $error("format select not followed");

    a_offr_follow: assert property ( // [RULE_03]
        1'b1 |=> ctrl.offset_range_select == $past(fmt_q[TFC_B_OFFR]))
        else $error("offset range not followed");

    a_pfn_follow: assert property ( // [RULE_10]
        1'b1 |=> ctrl.shared_pin_function == $past(pin_q[TFC_B_PFN +: 2]))
        else $error("pin function not followed");

    a_ftg_follow: assert property ( // [RULE_12]
        1'b1 |=> ctrl.overtemp_fan_target == $past(pin_q[TFC_B_FTG]))
        else $error("fan target not followed");

    a_byp_follow: assert property ( // [RULE_13]
        1'b1 |=>
        ctrl.core_voltage_attenuator_bypass == $past(pin_q[TFC_B_BYP]))
        else $error("attenuator bypass not followed");

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    a_read_valid: assert property ( // [RULE_10]
        s_read_pin |=> rvalid && hit && rdata == $past(pin_q))
        else $error("pin read data wrong");

    a_read_fmt: assert property ( // [RULE_16]
        s_read_fmt |=> rvalid && hit && rdata == $past(fmt_q))
        else $error("format read data wrong");

    a_read_test: assert property ( // [RULE_14]
        s_read_test |=> rvalid && hit && rdata == TFC_RST_TEST)
        else $error("test read data wrong");

    a_read_miss: assert property ( // [RULE_16]
        s_read_miss |=> rvalid && !hit && rdata == 8'h00)
        else $error("unmapped read not empty");

    a_read_idle: assert property ( // [RULE_16]
        !req.rd |=> !rvalid && !hit && rdata == 8'h00)
        else $error("read port busy while idle");
endmodule

// ---- testbench/tfc_host.sv ----
// Purpose: host model issuing register requests to the config block
// Assumes: requests change on the falling clock edge
// Notes: released write data shows the inverse of the last value
`timescale 1ns/1ps
module tfc_host (
    input wire logic clock,
    output tfc_pkg::tfc_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic hit
);
    import tfc_pkg::*;
    initial req = '0;
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        if (a == TFC_ADDR_TEST_A || a == TFC_ADDR_TEST_B) begin
            return;
        end
        @(negedge clock);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clock);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d,
                        output logic v, output logic h);
        @(negedge clock);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clock);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        d = rdata;
        v = rvalid;
        h = hit;
    endtask
endmodule

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench for the thermal fan config registers
// Assumes: host model drives requests, bench drives lock and limits
// Notes: outputs are checked after the two-cycle write latency
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
end
module testbench;
    import tfc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic lock = 1'b0;
    logic [23:0] overtemp_limits = 24'h202020;
    tfc_req_t req;
    logic [7:0] rdata, fmt_reg, pin_reg;
    logic rvalid, hit;
    tfc_ctrl_t ctrl;
    int checked = 0;
    int miscompares = 0;
    always #50 clock = ~clock;
    tfc_host i_host (.clock(clock), .req(req), .rdata(rdata),
        .rvalid(rvalid), .hit(hit));
    tfc_config_regs i_dut (.clock(clock), .rst(rst), .req(req),
        .lock(lock), .overtemp_limits(overtemp_limits), .rdata(rdata),
        .rvalid(rvalid), .hit(hit), .ctrl(ctrl), .fmt_reg(fmt_reg),
        .pin_reg(pin_reg));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.write(a, d);
        repeat (2) @(negedge clock);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e,
                          input logic eh);
        logic [7:0] d;
        logic v, h;
        i_host.read(a, d, v, h);
        `CHK("rvalid", 1'b1, v)
        `CHK("hit", eh, h)
        `CHK("rdata", e, d)
    endtask
    task automatic wrap_up;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk_rd(8'h7C, 8'h00, 1'b1);
        chk_rd(8'h7D, 8'h00, 1'b1);
        chk_rd(8'h7E, 8'h00, 1'b1);
        chk_rd(8'h7F, 8'h00, 1'b1);
        chk_rd(8'h10, 8'h00, 1'b0);
        `CHK("ote", 1'b1, ctrl.overtemp_output_enable)
        `CHK("chen", 3'b111, ctrl.overtemp_channel_enable)
        wr(8'h10, 8'hFF);
        wr(8'h7E, 8'hFF);
        chk_rd(8'h7C, 8'h00, 1'b1);
        chk_rd(8'h7D, 8'h00, 1'b1);
        chk_rd(8'h7E, 8'h00, 1'b1);
    endtask
    task automatic t_fmt;
        wr(8'h7C, 8'hFF);
        chk_rd(8'h7C, 8'hEF, 1'b1);
        `CHK("fmt_reg", 8'hEF, fmt_reg)
        `CHK("twos", 1'b1, ctrl.twos_complement_select)
        `CHK("offr", 1'b1, ctrl.offset_range_select)
        wr(8'h7C, 8'h00);
        `CHK("twos", 1'b0, ctrl.twos_complement_select)
        `CHK("offr", 1'b0, ctrl.offset_range_select)
    endtask
    task automatic t_pin;
        wr(8'h7C, 8'h0C);
        for (int k = 0; k < 4; k++) begin
            wr(8'h7D, 8'(k));
            `CHK("pfn", tfc_pin_fn_t'(k), ctrl.shared_pin_function)
            `CHK("gpen", (k == 3), ctrl.gpio_enabled)
            `CHK("gpout", (k == 3), ctrl.gpio_is_output)
        end
        `CHK("gphi", 1'b1, ctrl.gpio_active_high)
        wr(8'h7C, 8'h00);
        `CHK("gpen", 1'b1, ctrl.gpio_enabled)
        `CHK("gpout", 1'b0, ctrl.gpio_is_output)
        `CHK("gphi", 1'b0, ctrl.gpio_active_high)
        wr(8'h7D, 8'hFF);
        `CHK("pin_reg", 8'h2F, pin_reg)
        `CHK("ote", 1'b0, ctrl.overtemp_output_enable)
        `CHK("chen", 3'b000, ctrl.overtemp_channel_enable)
        `CHK("ftg", 1'b1, ctrl.overtemp_fan_target)
        `CHK("byp", 1'b1, ctrl.core_voltage_attenuator_bypass)
        wr(8'h7D, 8'h00);
        `CHK("pfn", TFC_PIN_TACH, ctrl.shared_pin_function)
        `CHK("ftg", 1'b0, ctrl.overtemp_fan_target)
        `CHK("byp", 1'b0, ctrl.core_voltage_attenuator_bypass)
        `CHK("ote", 1'b1, ctrl.overtemp_output_enable)
        `CHK("chen", 3'b111, ctrl.overtemp_channel_enable)
    endtask
    task automatic t_limits;
        @(negedge clock);
        overtemp_limits <= 24'h208000;
        wr(8'h7C, 8'h00);
        `CHK("chen", 3'b110, ctrl.overtemp_channel_enable)
        wr(8'h7C, 8'h01);
        `CHK("chen", 3'b101, ctrl.overtemp_channel_enable)
        overtemp_limits <= 24'h202020;
        wr(8'h7C, 8'hA0);
        `CHK("chen", 3'b010, ctrl.overtemp_channel_enable)
        wr(8'h7C, 8'h40);
        `CHK("chen", 3'b101, ctrl.overtemp_channel_enable)
    endtask
    task automatic t_lock;
        wr(8'h7C, 8'h01);
        lock <= 1'b1;
        repeat (3) @(negedge clock);
        wr(8'h7C, 8'h02);
        wr(8'h7D, 8'h03);
        chk_rd(8'h7C, 8'h01, 1'b1);
        chk_rd(8'h7D, 8'h00, 1'b1);
        `CHK("pin_reg", 8'h00, pin_reg)
        lock <= 1'b0;
        repeat (3) @(negedge clock);
    endtask
    task automatic t_rerst;
        wr(8'h7C, 8'h0F);
        wr(8'h7D, 8'h21);
        `CHK("fmt_reg", 8'h0F, fmt_reg)
        `CHK("pin_reg", 8'h21, pin_reg)
        rst <= 1'b1;
        repeat (2) @(negedge clock);
        `CHK("fmt_reg", 8'h00, fmt_reg)
        `CHK("pin_reg", 8'h00, pin_reg)
        `CHK("ctrl", tfc_ctrl_t'(0), ctrl)
        rst <= 1'b0;
        chk_rd(8'h7C, 8'h00, 1'b1);
        chk_rd(8'h7D, 8'h00, 1'b1);
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clock);
        rst <= 1'b0;
        t_reset();
        t_fmt();
        t_pin();
        t_limits();
        t_lock();
        t_rerst();
        wrap_up();
    end
    initial begin
        #(2000 * 100);
        miscompares++;
        wrap_up();
    end
endmodule
